// ==== common/tcr_params.svh ====
// named constants for the tile core resource block
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH
`define TCR_MAX_CORES   5
`define TCR_PIPE_DEPTH  4
`define TCR_MAX_LOCKS   4
`define TCR_TIMER_W     32
`define TCR_TICK_NS     10
`define TCR_CLK_NS      25
`define TCR_REF_MHZ     100
`define TCR_STREAM_MBPS 313
`define TCR_LINK_NARROW 2
`define TCR_LINK_WIDE   5
`define TCR_BITS_NARROW 2
`define TCR_BITS_WIDE   4
`define TCR_TOKEN_W     8
`define TCR_NPINS       8
`define TCR_P1_PIN      0
`define TCR_P4_PINS     4
`define TCR_P8_PINS     8
`define TCR_CBIN_PIN    6
`define TCR_CBOUT_PIN   7
`define TCR_DIV_W       8
`endif

// ==== common/tcr_pkg.sv ====
// types shared by the tile core resource modules
package tcr_pkg;
  typedef logic [2:0] tcr_core_t;
  typedef logic [1:0] tcr_lock_t;
  typedef logic [7:0] tcr_token_t;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_SYNC = 2'h1,
    OP_ACQ  = 2'h3,
    OP_REL  = 2'h2
  } tcr_op_e;
  typedef enum logic [1:0] {
    LK_IDLE = 2'h0,
    LK_SEND = 2'h1
  } tcr_link_e;
endpackage

// ==== common/tcr_sync_if.sv ====
// issued synchronisation and lock operations, and the blocked-core mask
`timescale 1ns/100ps
interface tcr_sync_if import tcr_pkg::*; #(
  parameter int NCORES = 5
) ();
  logic              opValid;
  tcr_core_t         opCore;
  tcr_op_e           opKind;
  tcr_lock_t         opLock;
  logic [NCORES-1:0] group;
  logic [NCORES-1:0] blocked;
  modport issuer (output opValid, output opCore, output opKind, output opLock,
                  output group, input blocked);
  modport keeper (input opValid, input opCore, input opKind, input opLock,
                  input group, output blocked);
endinterface // tcr_sync_if

// ==== design/tcr_lock_sync.sv ====
// barrier synchroniser and mutual exclusion locks
`timescale 1ns/100ps
`include "tcr_params.svh"
module tcr_lock_sync import tcr_pkg::*; #(
  parameter int NCORES = `TCR_MAX_CORES,
  parameter int NLOCKS = `TCR_MAX_LOCKS
) (
  input wire logic mclk,
  input wire logic rst,
  tcr_sync_if.keeper sif
);
  logic [NCORES-1:0] arrived_r;
  logic [NCORES-1:0] opBit;
  logic [NCORES-1:0] lockWait [NLOCKS];

  assign opBit = NCORES'(1) << sif.opCore;

  // barrier: the last member to arrive releases the whole group at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      arrived_r <= '0;
    end else if (sif.opValid && sif.opKind == OP_SYNC) begin
      if (((arrived_r | opBit) & sif.group) == sif.group) begin
        arrived_r <= arrived_r & ~sif.group;
      end else begin
        arrived_r <= arrived_r | opBit;
      end
    end
  end

  // one ownership record and one waiting set per lock
  genvar l;
  generate
    for (l = 0; l < NLOCKS; l++) begin : g_lock
      logic              held_r;
      tcr_core_t         owner_r;
      logic [NCORES-1:0] wait_r;
      logic              acq;
      logic              rel;
      logic              anyWait;
      tcr_core_t         nextOwner;
      assign acq = sif.opValid && sif.opKind == OP_ACQ && sif.opLock == tcr_lock_t'(l);
      assign rel = sif.opValid && sif.opKind == OP_REL && sif.opLock == tcr_lock_t'(l)
                   && held_r && owner_r == sif.opCore;
      // fair hand-over: first waiter after the current owner
      always_comb begin
        int idx;
        idx = 0;
        anyWait = 1'b0;
        nextOwner = owner_r;
        for (int k = NCORES; k >= 1; k--) begin
          idx = (int'(owner_r) + k) % NCORES;
          if (wait_r[idx]) begin
            anyWait = 1'b1;
            nextOwner = tcr_core_t'(idx);
          end
        end
      end
      always_ff @(posedge mclk) begin
        if (rst) begin
          held_r  <= 1'b0;
          owner_r <= '0;
          wait_r  <= '0;
        end else if (acq && !held_r) begin
          held_r  <= 1'b1;
          owner_r <= sif.opCore;
        end else if (acq && owner_r != sif.opCore) begin
          wait_r <= wait_r | opBit;
        end else if (rel && anyWait) begin
          owner_r <= nextOwner;
          wait_r  <= wait_r & ~(NCORES'(1) << nextOwner);
        end else if (rel) begin
          held_r <= 1'b0;
        end
      end
      assign lockWait[l] = wait_r;
    end
  endgenerate

  // a core stays blocked while parked on the barrier or on any lock
  always_comb begin
    sif.blocked = arrived_r;
    for (int i = 0; i < NLOCKS; i++) begin
      sif.blocked = sif.blocked | lockWait[i];
    end
  end
endmodule // tcr_lock_sync

// ==== design/tcr_top.sv ====
// tile core resources: issue, timer, pin mux, clock blocks, link sender
`timescale 1ns/100ps
`include "tcr_params.svh"
module tcr_top import tcr_pkg::*; #(
  parameter int NCORES = `TCR_MAX_CORES,
  parameter int NLOCKS = `TCR_MAX_LOCKS,
  parameter int NCONN  = 2,
  parameter int NCB    = 2
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic [NCORES-1:0]      coreActive,
  input  wire logic [NCORES-1:0]      coreIoWait,
  input  tcr_op_e                     coreOp [NCORES],
  input  tcr_lock_t                   coreLock [NCORES],
  input  wire logic [NCORES-1:0]      syncGroup,
  output logic                        issueValid,
  output tcr_core_t                   issueCore,
  input  wire logic                   cfgWr,
  input  wire logic                   cfgLinkEn,
  input  wire logic                   cfgLinkWide,
  input  wire logic [NCONN-1:0]       cfgConnStream,
  input  wire logic [2:0]             cfgPortEn,
  input  wire logic [2:0]             cfgPortOut,
  input  wire logic [$clog2(NCB)-1:0] cfgPortCb [3],
  input  wire logic [NCB-1:0]         cfgCbExt,
  input  wire logic [`TCR_DIV_W-1:0]  cfgCbDiv [NCB],
  input  wire logic [NCB-1:0]         cfgCbDrive,
  input  wire logic                   p1Wdata,
  input  wire logic [3:0]             p4Wdata,
  input  wire logic [7:0]             p8Wdata,
  output logic                        p1Rdata,
  output logic [3:0]                  p4Rdata,
  output logic [7:0]                  p8Rdata,
  input  wire logic [`TCR_NPINS-1:0]  pinIn,
  output logic [`TCR_NPINS-1:0]       pinOut,
  output logic [`TCR_NPINS-1:0]       pinOe,
  input  wire logic [NCONN-1:0]       connValid,
  input  tcr_token_t                  connData [NCONN],
  input  wire logic [NCONN-1:0]       connEnd,
  output logic [NCONN-1:0]            connTaken,
  output logic                        linkWideOut,
  output logic [`TCR_TIMER_W-1:0]     timerCount
);
  localparam int CBW = $clog2(NCB);
  localparam int CNW = (NCONN > 1) ? $clog2(NCONN) : 1;
  localparam int CLK_NS = `TCR_CLK_NS;
  localparam int TICK_NS = 1000 / `TCR_REF_MHZ;
  localparam int CD_LOAD = `TCR_PIPE_DEPTH - 1;

  generate
    if (NCORES < 1 || NCORES > `TCR_MAX_CORES || NLOCKS < 1 || NLOCKS > `TCR_MAX_LOCKS
        || NCB < 2 || NCONN < 1 || TICK_NS != `TCR_TICK_NS) begin : g_bad
      $error("tcr_top: parameter out of range");
    end
  endgenerate

  // ---- issue scheduler ----
  tcr_sync_if #(.NCORES(NCORES)) sif ();
  tcr_lock_sync #(.NCORES(NCORES), .NLOCKS(NLOCKS)) u_lock_sync (
    .mclk (mclk),
    .rst  (rst),
    .sif  (sif.keeper)
  );

  logic [1:0]        cd_r [NCORES];
  logic [NCORES-1:0] eligible;
  tcr_core_t         lastCore_r;
  tcr_core_t         pick;
  logic              anyElig;

  // a core re-issues only once its previous instruction left the pipeline
  genvar c;
  generate
    for (c = 0; c < NCORES; c++) begin : g_core
      assign eligible[c] = coreActive[c] && !coreIoWait[c] && !sif.blocked[c]
                           && cd_r[c] == 2'h0;
      always_ff @(posedge mclk) begin
        if (rst) begin
          cd_r[c] <= 2'h0;
        end else if (anyElig && pick == tcr_core_t'(c)) begin
          cd_r[c] <= 2'(CD_LOAD);
        end else if (cd_r[c] != 2'h0) begin
          cd_r[c] <= cd_r[c] - 2'h1;
        end
      end
    end
  endgenerate

  // round-robin search starting just after the last issued core
  always_comb begin
    int idx;
    idx = 0;
    anyElig = 1'b0;
    pick = lastCore_r;
    for (int k = NCORES; k >= 1; k--) begin
      idx = (int'(lastCore_r) + k) % NCORES;
      if (eligible[idx]) begin
        anyElig = 1'b1;
        pick = tcr_core_t'(idx);
      end
    end
  end

  // empty slot when no core may issue; five ready cores share one in five
  always_ff @(posedge mclk) begin
    if (rst) begin
      issueValid <= 1'b0;
      issueCore  <= '0;
      lastCore_r <= tcr_core_t'(NCORES - 1);
    end else begin
      issueValid <= anyElig;
      issueCore  <= pick;
      if (anyElig) begin
        lastCore_r <= pick;
      end
    end
  end

  assign sif.opValid = anyElig;
  assign sif.opCore  = pick;
  assign sif.opKind  = coreOp[pick];
  assign sif.opLock  = coreLock[pick];
  assign sif.group   = syncGroup;

  // ---- timer: 25 ns clock carries 10 ns ticks as a remainder ----
  logic [7:0] rem_r;
  logic [7:0] sum;
  assign sum = rem_r + 8'(CLK_NS);
  always_ff @(posedge mclk) begin
    if (rst) begin
      rem_r      <= 8'h00;
      timerCount <= '0;
    end else begin
      rem_r      <= sum % 8'(TICK_NS);
      timerCount <= timerCount + `TCR_TIMER_W'(sum / 8'(TICK_NS));
    end
  end

  // ---- configuration, loaded as one image on cfgWr ----
  logic                 linkEn_r;
  logic                 linkWide_r;
  logic [NCONN-1:0]     stream_r;
  logic [2:0]           portEn_r;
  logic [2:0]           portOut_r;
  logic [CBW-1:0]       portCb_r [3];
  logic [NCB-1:0]       cbExt_r;
  logic [`TCR_DIV_W-1:0] cbDiv_r [NCB];
  logic [NCB-1:0]       cbDrive_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      linkEn_r   <= 1'b0;
      linkWide_r <= 1'b0;
      stream_r   <= '0;
      portEn_r   <= 3'h0;
      portOut_r  <= 3'h0;
      portCb_r   <= '{default: '0};
      cbExt_r    <= '0;
      cbDiv_r    <= '{default: '0};
      cbDrive_r  <= '0;
    end else if (cfgWr) begin
      linkEn_r   <= cfgLinkEn;
      linkWide_r <= cfgLinkWide;
      stream_r   <= cfgConnStream;
      portEn_r   <= cfgPortEn;
      portOut_r  <= cfgPortOut;
      portCb_r   <= cfgPortCb;
      cbExt_r    <= cfgCbExt;
      cbDiv_r    <= cfgCbDiv;
      cbDrive_r  <= cfgCbDrive;
    end
  end
  assign linkWideOut = linkWide_r;

  // ---- clock blocks: pin edge or divided reference ----
  logic                  cbPinPrev_r;
  logic [NCB-1:0]        cbTick_r;
  logic [NCB-1:0]        cbLevel_r;
  logic [`TCR_DIV_W-1:0] cbCnt_r [NCB];
  genvar b;
  generate
    for (b = 0; b < NCB; b++) begin : g_cb
      always_ff @(posedge mclk) begin
        if (rst) begin
          cbCnt_r[b]   <= '0;
          cbTick_r[b]  <= 1'b0;
          cbLevel_r[b] <= 1'b0;
        end else begin
          if (cbExt_r[b]) begin
            cbTick_r[b] <= pinIn[`TCR_CBIN_PIN] && !cbPinPrev_r;
            cbCnt_r[b]  <= '0;
          end else if (cbCnt_r[b] >= cbDiv_r[b]) begin
            cbTick_r[b] <= 1'b1;
            cbCnt_r[b]  <= '0;
          end else begin
            cbTick_r[b] <= 1'b0;
            cbCnt_r[b]  <= cbCnt_r[b] + 1'b1;
          end
          if (cbTick_r[b]) begin
            cbLevel_r[b] <= !cbLevel_r[b];
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (rst) begin
      cbPinPrev_r <= 1'b0;
    end else begin
      cbPinPrev_r <= pinIn[`TCR_CBIN_PIN];
    end
  end

  // ---- ports: latch on their clock block tick, whole width always ----
  logic       p1Lat_r;
  logic [3:0] p4Lat_r;
  logic [7:0] p8Lat_r;
  logic [2:0] portTick;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      portTick[i] = cbTick_r[portCb_r[i]];
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      p1Lat_r <= 1'b0;
      p4Lat_r <= 4'h0;
      p8Lat_r <= 8'h00;
      p1Rdata <= 1'b0;
      p4Rdata <= 4'h0;
      p8Rdata <= 8'h00;
    end else begin
      if (portTick[0] && portOut_r[0]) p1Lat_r <= p1Wdata;
      if (portTick[1] && portOut_r[1]) p4Lat_r <= p4Wdata;
      if (portTick[2] && portOut_r[2]) p8Lat_r <= p8Wdata;
      // inputs sample every pin of the port even when another owns some
      if (portTick[0] && !portOut_r[0]) p1Rdata <= pinIn[`TCR_P1_PIN];
      if (portTick[1] && !portOut_r[1]) p4Rdata <= pinIn[`TCR_P4_PINS-1:0];
      if (portTick[2] && !portOut_r[2]) p8Rdata <= pinIn[`TCR_P8_PINS-1:0];
    end
  end

  // ---- pin mux: link, clock out, then narrowest port first ----
  logic [4:0] lnkWire_r;
  logic       cbOutOn;
  logic       cbOutVal;
  int         linkLanes;
  assign linkLanes = linkWide_r ? `TCR_LINK_WIDE : `TCR_LINK_NARROW;
  always_comb begin
    cbOutOn = 1'b0;
    cbOutVal = 1'b0;
    for (int i = NCB - 1; i >= 0; i--) begin
      if (cbDrive_r[i]) begin
        cbOutOn = 1'b1;
        cbOutVal = cbLevel_r[i];
      end
    end
  end
  genvar p;
  generate
    for (p = 0; p < `TCR_NPINS; p++) begin : g_pin
      logic oNxt;
      logic eNxt;
      always_comb begin
        oNxt = 1'b0;
        eNxt = 1'b0;
        if (linkEn_r && p < linkLanes) begin
          oNxt = lnkWire_r[p % 5];
          eNxt = 1'b1;
        end else if (cbOutOn && p == `TCR_CBOUT_PIN) begin
          oNxt = cbOutVal;
          eNxt = 1'b1;
        end else if (portEn_r[0] && p == `TCR_P1_PIN) begin
          oNxt = p1Lat_r;
          eNxt = portOut_r[0];
        end else if (portEn_r[1] && p < `TCR_P4_PINS) begin
          oNxt = p4Lat_r[p % 4];
          eNxt = portOut_r[1];
        end else if (portEn_r[2] && p < `TCR_P8_PINS) begin
          oNxt = p8Lat_r[p];
          eNxt = portOut_r[2];
        end
      end
      always_ff @(posedge mclk) begin
        if (rst) begin
          pinOut[p] <= 1'b0;
          pinOe[p]  <= 1'b0;
        end else begin
          pinOut[p] <= oNxt;
          pinOe[p]  <= eNxt;
        end
      end
    end
  endgenerate

  // ---- link sender: the single link toward the switch and analog node ----
  tcr_link_e      lkState_r;
  logic [CNW-1:0] owner_r;
  logic           pktOpen_r;
  logic           strm_r;
  tcr_token_t     shift_r;
  logic [2:0]     beats_r;
  logic           reserved;
  logic           candOk;
  logic [CNW-1:0] cand;
  assign reserved = pktOpen_r || (strm_r && stream_r[owner_r]);
  always_comb begin
    int idx;
    idx = 0;
    cand = owner_r;
    candOk = 1'b0;
    if (reserved) begin
      candOk = connValid[owner_r];
    end else begin
      for (int k = NCONN; k >= 1; k--) begin
        idx = (int'(owner_r) + k) % NCONN;
        if (connValid[idx]) begin
          candOk = 1'b1;
          cand = CNW'(idx);
        end
      end
    end
  end
  // narrow mode carries no beat marker; framing is left to the far end
  always_ff @(posedge mclk) begin
    if (rst || !linkEn_r) begin
      lkState_r <= LK_IDLE;
      owner_r   <= '0;
      pktOpen_r <= 1'b0;
      strm_r    <= 1'b0;
      shift_r   <= '0;
      beats_r   <= 3'h0;
      lnkWire_r <= 5'h00;
      connTaken <= '0;
    end else begin
      connTaken <= '0;
      case (lkState_r)
        LK_IDLE: begin
          lnkWire_r <= 5'h00;
          if (candOk) begin
            owner_r   <= cand;
            connTaken <= NCONN'(1) << cand;
            shift_r   <= connData[cand];
            strm_r    <= stream_r[cand];
            pktOpen_r <= !stream_r[cand] && !connEnd[cand];
            beats_r   <= linkWide_r ? 3'(`TCR_TOKEN_W / `TCR_BITS_WIDE)
                                    : 3'(`TCR_TOKEN_W / `TCR_BITS_NARROW);
            lkState_r <= LK_SEND;
          end
        end
        LK_SEND: begin
          if (linkWide_r) begin
            lnkWire_r <= {1'b1, shift_r[3:0]};
            shift_r   <= shift_r >> `TCR_BITS_WIDE;
          end else begin
            lnkWire_r <= {3'h0, shift_r[1:0]};
            shift_r   <= shift_r >> `TCR_BITS_NARROW;
          end
          beats_r <= beats_r - 3'h1;
          if (beats_r == 3'h1) begin
            lkState_r <= LK_IDLE;
          end
        end
        default: lkState_r <= LK_IDLE;
      endcase
    end
  end
endmodule // tcr_top

// ==== tb/tcr_top_asserts.sv ====
// port-level checks for the tile core resource top
`timescale 1ns/100ps
module tcr_top_asserts import tcr_pkg::*; #(
  parameter int NCORES = 5,
  parameter int NCONN  = 2
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic [NCORES-1:0] coreActive,
  input wire logic [NCORES-1:0] coreIoWait,
  input wire logic              cfgWr,
  input wire logic              cfgLinkWide,
  input wire logic [NCONN-1:0]  connValid,
  input wire logic [NCONN-1:0]  connTaken,
  input wire logic              issueValid,
  input tcr_core_t              issueCore,
  input wire logic              linkWideOut,
  input wire logic [31:0]       timerCount
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // one clock domain, so every property shares this clock and reset
  property p_core_range;
    issueValid |-> issueCore < NCORES;
  endproperty
  a_core_range: assert property (p_core_range) else $error("issued core out of range");
  property p_issue_gap;
    issueValid |-> !($past(issueValid, 1) && $past(issueCore, 1) == issueCore)
      && !($past(issueValid, 2) && $past(issueCore, 2) == issueCore)
      && !($past(issueValid, 3) && $past(issueCore, 3) == issueCore);
  endproperty
  a_issue_gap: assert property (p_issue_gap) else $error("core issued twice in 4");
  property p_issue_elig;
    issueValid |-> ((($past(coreActive) & ~$past(coreIoWait)) >> issueCore) & 1) != 0;
  endproperty
  a_issue_elig: assert property (p_issue_elig) else $error("idle core issued");
  property p_taken_one;
    $onehot0(connTaken);
  endproperty
  a_taken_one: assert property (p_taken_one) else $error("two tokens taken");
  property p_taken_cause;
    connTaken != 0 |-> (connTaken & ~$past(connValid)) == 0;
  endproperty
  a_taken_cause: assert property (p_taken_cause) else $error("token without request");
  property p_link_width;
    cfgWr ##1 !cfgWr ##1 !cfgWr |-> linkWideOut == $past(cfgLinkWide, 2);
  endproperty
  a_link_width: assert property (p_link_width) else $error("link width not loaded");
  property p_timer_step;
    !$past(rst) |-> (timerCount - $past(timerCount)) inside {32'h2, 32'h3};
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer step wrong");
  property p_timer_pair;
    !$past(rst) && !$past(rst, 2) |-> (timerCount - $past(timerCount, 2)) == 32'h5;
  endproperty
  a_timer_pair: assert property (p_timer_pair) else $error("timer rate wrong");
endmodule // tcr_top_asserts

bind tcr_top tcr_top_asserts #(.NCORES(NCORES), .NCONN(NCONN)) u_chk (
  .mclk(mclk), .rst(rst), .coreActive(coreActive), .coreIoWait(coreIoWait),
  .cfgWr(cfgWr), .cfgLinkWide(cfgLinkWide), .connValid(connValid),
  .connTaken(connTaken), .issueValid(issueValid), .issueCore(issueCore),
  .linkWideOut(linkWideOut), .timerCount(timerCount));

// ==== tb/tcr_link_rx.sv ====
// far-end switch model: rebuilds tokens from wide link beats
`timescale 1ns/100ps
module tcr_link_rx (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  output logic [7:0]     rxXor,
  output int             rxCount
);
  logic [3:0] lowNib_r;
  logic       half_r;
  // wire 4 marks a data beat; low nibble comes first
  always_ff @(posedge mclk) begin
    if (rst) begin
      half_r  <= 1'b0;
      rxXor   <= 8'h00;
      rxCount <= 0;
    end else if (pinOe[4] && pinOut[4]) begin
      half_r   <= !half_r;
      lowNib_r <= pinOut[3:0];
      if (half_r) begin
        rxXor   <= rxXor ^ {pinOut[3:0], lowNib_r};
        rxCount <= rxCount + 1;
      end
    end
  end
endmodule // tcr_link_rx

// ==== tb/tb.sv ====
// self-checking bench for the tile core resource top
`timescale 1ns/100ps
module tb import tcr_pkg::*;;
  logic        mclk = 0, rst = 1, cfgWr, cfgLinkEn, cfgLinkWide, issueValid;
  logic [4:0]  coreActive, coreIoWait, syncGroup;
  tcr_op_e     coreOp [5];
  tcr_lock_t   coreLock [5];
  tcr_core_t   issueCore;
  logic [1:0]  cfgConnStream, cfgCbExt, cfgCbDrive, connValid, connEnd, connTaken;
  logic [2:0]  cfgPortEn, cfgPortOut;
  logic [0:0]  cfgPortCb [3];
  logic [7:0]  cfgCbDiv [2], p8Wdata, p8Rdata, pinIn, pinOut, pinOe, rxXor;
  logic        p1Wdata, p1Rdata, linkWideOut;
  logic [3:0]  p4Wdata, p4Rdata;
  tcr_token_t  connData [2];
  logic [31:0] timerCount, t0;
  int          n_errors, num_checks, cycles, rxCount, cnt [5];

  tcr_top #(.NCORES(5), .NLOCKS(4), .NCONN(2), .NCB(2)) i_dut (
    .mclk(mclk), .rst(rst), .coreActive(coreActive), .coreIoWait(coreIoWait),
    .coreOp(coreOp), .coreLock(coreLock), .syncGroup(syncGroup),
    .issueValid(issueValid), .issueCore(issueCore), .cfgWr(cfgWr),
    .cfgLinkEn(cfgLinkEn), .cfgLinkWide(cfgLinkWide), .cfgConnStream(cfgConnStream),
    .cfgPortEn(cfgPortEn), .cfgPortOut(cfgPortOut), .cfgPortCb(cfgPortCb),
    .cfgCbExt(cfgCbExt), .cfgCbDiv(cfgCbDiv), .cfgCbDrive(cfgCbDrive),
    .p1Wdata(p1Wdata), .p4Wdata(p4Wdata), .p8Wdata(p8Wdata), .p1Rdata(p1Rdata),
    .p4Rdata(p4Rdata), .p8Rdata(p8Rdata), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .connValid(connValid), .connData(connData), .connEnd(connEnd),
    .connTaken(connTaken), .linkWideOut(linkWideOut), .timerCount(timerCount));
  tcr_link_rx i_rx (.mclk(mclk), .rst(rst), .pinOut(pinOut), .pinOe(pinOe),
                    .rxXor(rxXor), .rxCount(rxCount));

  always #12.5 mclk = ~mclk;
  // per-core issue tally, cleared by scenarios at the falling edge
  always @(posedge mclk) begin
    cycles++;
    if (issueValid === 1'b1 && issueCore < 5) cnt[issueCore] <= cnt[issueCore] + 1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask
  task automatic count(input int n);
    foreach (cnt[i]) cnt[i] = 0;
    repeat (n) @(negedge mclk);
  endtask
  task automatic cfg_write();
    @(negedge mclk) cfgWr = 1;
    @(negedge mclk) cfgWr = 0;
    repeat (6) @(negedge mclk);
  endtask
  // share of issue slots for a set of running and stalled cores
  task automatic t_share(input logic [4:0] act, iow, input int e);
    coreActive = act;
    coreIoWait = iow;
    repeat (8) @(negedge mclk);
    count(40);
    for (int i = 0; i < 5; i++) check(cnt[i], (act[i] && !iow[i]) ? e : 0, "issue count");
  endtask
  task automatic t_sync();
    coreActive = 5'h07;
    syncGroup = 5'h03;
    coreOp[0] = OP_SYNC;
    count(20);
    check(cnt[0], 1, "core0 held at barrier");
    check(cnt[2], 5, "free core keeps slots");
    coreOp[1] = OP_SYNC;
    count(20);
    check(cnt[0] >= 2, 1, "barrier released");
    coreOp = '{default: OP_NONE};
  endtask
  task automatic t_lock();
    // mid-run reset: the barrier test can leave a core parked, and this frees it
    rst = 1;
    coreActive = 5'h03;
    coreLock = '{default: 2'h2};
    coreOp[0] = OP_ACQ;
    coreOp[1] = OP_ACQ;
    repeat (4) @(negedge mclk);
    check({issueValid, pinOe}, 0, "outputs in mid-run reset");
    rst = 0;
    count(20);
    check(cnt[0] + cnt[1], 6, "one owner, one waiter");
    coreOp = '{default: OP_REL};
    count(20);
    check(cnt[0] >= 2 && cnt[1] >= 2, 1, "waiter granted");
    coreOp = '{default: OP_NONE};
  endtask
  task automatic t_ports();
    cfgPortEn = 3'b011;
    cfgPortOut = 3'b011;
    cfgCbDrive = 2'b01;
    p1Wdata = 1;
    p4Wdata = 4'ha;
    cfg_write();
    check(pinOut[3:0], 4'hb, "narrow port owns pin0");
    check(pinOe[3:0], 4'hf, "output pins driven");
    check(pinOe[7], 1, "clock out pin");
    cfgPortEn = 3'b100;
    cfgPortOut = 3'b000;
    cfgCbDrive = 2'b00;
    cfgCbExt = 2'b01;
    pinIn = 8'h1d;
    cfg_write();
    check(p8Rdata, 8'h1d, "wide input read");
    check(p4Rdata, 4'hd, "4bit input read");
    check(p1Rdata, 1, "1bit input read");
    check(pinOe, 8'h00, "input port drives nothing");
    // block 0 now runs from the pin: data alone must not be sampled
    pinIn = 8'h1e;
    repeat (4) @(negedge mclk);
    check(p8Rdata, 8'h1d, "no pin clock edge, no sample");
    pinIn = 8'h5e;
    repeat (4) @(negedge mclk);
    check(p8Rdata, 8'h5e, "pin clock edge samples");
    cfgCbExt = 2'b00;
    cfgPortEn = 3'b001;
    cfgPortOut = 3'b001;
    cfgLinkEn = 1;
    cfg_write();
    check(pinOut[0], 0, "link takes port pins");
    check(linkWideOut, 0, "narrow link");
  endtask
  task automatic send(input int c, input tcr_token_t d);
    int k;
    @(negedge mclk);
    connValid[c] = 1;
    connData[c] = d;
    connEnd[c] = 1;
    for (k = 0; k < 200 && connTaken[c] !== 1'b1; k++) @(negedge mclk);
    connValid[c] = 0;
    check(k < 200, 1, "token accepted");
  endtask
  task automatic t_link();
    cfgLinkWide = 1;
    cfgPortEn = 3'b000;
    cfg_write();
    fork
      send(0, 8'ha5);
      send(1, 8'h3c);
    join
    repeat (12) @(negedge mclk);
    check(rxCount, 2, "tokens delivered");
    check(rxXor, 8'h99, "token contents");
    cfgConnStream = 2'b01;
    cfg_write();
    send(0, 8'h11);
    repeat (12) @(negedge mclk);
    check(rxXor, 8'h88, "stream token");
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {cfgWr, cfgLinkEn, cfgLinkWide, cfgConnStream, cfgCbExt, cfgCbDrive} = '0;
    {coreActive, coreIoWait, syncGroup, cfgPortEn, cfgPortOut} = '0;
    {p1Wdata, p4Wdata, p8Wdata, pinIn, connValid, connEnd} = '0;
    coreOp = '{default: OP_NONE};
    coreLock = '{default: 2'h0};
    cfgPortCb = '{default: 1'b0};
    cfgCbDiv = '{default: 8'h00};
    connData = '{default: 8'h00};
    repeat (12) @(negedge mclk);
    check(timerCount, 0, "timer in reset");
    check({issueValid, pinOe}, 0, "outputs in reset");
    rst = 0;
    repeat (4) @(negedge mclk);
    t0 = timerCount;
    repeat (10) @(negedge mclk);
    check(timerCount - t0, 25, "timer rate");
    t_share(5'h01, 5'h00, 10);
    t_share(5'h07, 5'h00, 10);
    t_share(5'h1f, 5'h00, 8);
    t_share(5'h1f, 5'h10, 10);
    t_sync();
    t_lock();
    t_ports();
    t_link();
    conclude();
  end
endmodule // tb
